// ### design/tc16_regs.svh
// Register offsets, field positions and reset values of the 16-bit timer.
// Assumes byte addresses on a 32-bit APB with one aligned word a register.
`ifndef TC16_REGS_SVH
`define TC16_REGS_SVH

// Byte offsets of the registers.
`define TC16_OFS_CTRL     8'h00
`define TC16_OFS_COUNT    8'h04
`define TC16_OFS_CCA      8'h08
`define TC16_OFS_CCB      8'h0c
`define TC16_OFS_STATUS   8'h10
`define TC16_OFS_MASK     8'h14

// Control register fields.
`define TC16_CTRL_MODE_LO 0
`define TC16_CTRL_MODE_HI 1
`define TC16_CTRL_CAPT_A  2
`define TC16_CTRL_PIN_OUT 3
`define TC16_CTRL_W       4

// Mode codes held in the two mode-select bits.
`define TC16_MODE_STOP    2'h0
`define TC16_MODE_CLR_EDG 2'h1
`define TC16_MODE_FREE    2'h2
`define TC16_MODE_CLR_MAT 2'h3

// Status and mask bit positions.
`define TC16_ST_CMP_A     0
`define TC16_ST_OVF       1
`define TC16_ST_CAPT_A    2
`define TC16_ST_CAPT_B    3
`define TC16_ST_W         4

// Reset values.
`define TC16_RST_CTRL     4'h0
`define TC16_RST_MASK     4'h0
`define TC16_RST_CC       16'h0000

`endif

// ### design/tc16_pkg.sv
// Types shared by the timer files.
// Assumes the constants of tc16_regs.svh for field positions.
package tc16_pkg;

    // Width of the counter and of both capture/compare registers.
    typedef logic [15:0] tc16_count_t;

    // Operating mode held in the two mode-select bits.
    typedef logic [1:0]  tc16_mode_t;

endpackage

// ### design/tc16_edge_sync.sv
// Two-stage synchroniser with a rising-edge pulse for one pin input.
// Assumes an asynchronous pin and the block clock clk.
`timescale 1ns/100ps
`default_nettype none

module tc16_edge_sync (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst_b,
    // Pin side.
    input  wire logic pin_i,
    // Synchronised side.
    output logic      level_o,
    output logic      rise_o
);

    logic meta_ff;
    logic sync_ff;
    logic last_ff;

    // Only sync_ff reads the first stage, so no logic sees a metastable value.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            last_ff <= 1'b0;
        end else begin
            meta_ff <= pin_i;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    // Edge pulse is one cycle wide.
    assign level_o = sync_ff;
    assign rise_o  = sync_ff & ~last_ff;

endmodule

`default_nettype wire

// ### design/tc16_timer.sv
// 16-bit timer/event counter with capture/compare registers and APB access.
// Assumes an APB master on clk, and edge pins that are asynchronous to clk.
//
// Function
// - Counter reads pause counting briefly; the missed step is repaid.
// - Compare value zero matches only on zero-to-one after wrap.
// - Compare below count: keep counting, wrap, no match meanwhile.
// - Compare mode ignores capture trigger edges on input a; pin b still captures into register b.
// - Shared pin is either capture input or timer output, never both.
// - Capture beats a coinciding read; read data then undefined.
// - Capture coinciding with stop gives undefined captured value.
// - Reading the counter never captures into register b.
// - Counter runs while mode bits nonzero, stops when both zero.
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none

`include "tc16_regs.svh"

module tc16_timer
    import tc16_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst_b,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Edge input a, capture and clear trigger.
    input  wire logic        edge_input_a,
    // Shared port pin: edge input b or timer output.
    input  wire logic        shared_port_pin_i,
    output logic             shared_port_pin_o,
    output logic             shared_port_pin_oe_b,
    // Interrupt.
    output logic             compare_a_irq
);

    // The counter width is fixed by the register layout.
    generate
        if (CNT_W != 16) begin : g_bad_width
            $error("tc16_timer supports only CNT_W of 16");
        end
    endgenerate

    // Synchronised pin inputs; only the edges matter, not the levels.
    logic edge_a_rise;
    logic pin_b_rise;

    tc16_edge_sync u_sync_a (
        .clk     (clk),
        .rst_b   (rst_b),
        .pin_i   (edge_input_a),
        .level_o (),
        .rise_o  (edge_a_rise)
    );

    tc16_edge_sync u_sync_b (
        .clk     (clk),
        .rst_b   (rst_b),
        .pin_i   (shared_port_pin_i),
        .level_o (),
        .rise_o  (pin_b_rise)
    );

    // Registered state.
    logic [`TC16_CTRL_W-1:0] ctrl_ff,  nxt_ctrl;
    logic [`TC16_ST_W-1:0]   stat_ff,  nxt_stat;
    logic [`TC16_ST_W-1:0]   mask_ff,  nxt_mask;
    tc16_count_t             cnt_ff,   nxt_cnt;
    tc16_count_t             cca_ff,   nxt_cca;
    tc16_count_t             ccb_ff,   nxt_ccb;
    logic                    owe_ff,   nxt_owe;
    logic                    wrap_ff,  nxt_wrap;
    logic                    tout_ff,  nxt_tout;
    logic                    oe_b_ff,  nxt_oe_b;
    logic                    irq_ff,   nxt_irq;
    logic [31:0]             rdat_ff,  nxt_rdat;
    logic                    rdy_ff,   nxt_rdy;
    logic                    err_ff,   nxt_err;

    // Decoded bus and mode terms.
    tc16_mode_t  mode;
    logic        running;
    logic        capt_mode;
    logic        pin_out;
    logic        setup;
    logic        done;
    logic        wr;
    logic        rd;
    logic        mapped;
    logic        cnt_gate;
    logic        match_a;
    logic        cca_zero_ok;
    tc16_count_t cnt_plus1;
    tc16_count_t cnt_step;
    logic        capt_a;
    logic        capt_b;
    logic        wrap_now;

    assign mode      = ctrl_ff[`TC16_CTRL_MODE_HI:`TC16_CTRL_MODE_LO];
    assign running   = (mode != `TC16_MODE_STOP);
    assign capt_mode = ctrl_ff[`TC16_CTRL_CAPT_A];
    assign pin_out   = ctrl_ff[`TC16_CTRL_PIN_OUT];
    assign setup     = psel & ~penable;
    assign done      = psel & penable & rdy_ff;
    assign wr        = done & pwrite;
    assign rd        = done & ~pwrite;
    assign cnt_plus1 = cnt_ff + 16'h0001;

    // Address decode for the mapped words.
    always_comb begin
        case (paddr)
            `TC16_OFS_CTRL,
            `TC16_OFS_COUNT,
            `TC16_OFS_CCA,
            `TC16_OFS_CCB,
            `TC16_OFS_STATUS,
            `TC16_OFS_MASK: mapped = 1'b1;
            default:        mapped = 1'b0;
        endcase
    end

    // The count clock is held off for the access phase of a counter read, so
    // the value on the bus stays steady; the skipped step is owed and paid.
    assign cnt_gate = psel & penable & ~pwrite
                    & (paddr == `TC16_OFS_COUNT);

    // A step of two pays the owed count, and a match on the skipped value
    // is still seen through the second term below.
    assign cnt_step = owe_ff ? cnt_ff + 16'h0002 : cnt_plus1;

    // Zero compare value may only match once the counter has wrapped, so the
    // start from zero does not count as a match.
    assign cca_zero_ok = (cca_ff != 16'h0000) | wrap_ff;

    // Equality only: a compare value below the count waits for the wrap.
    assign match_a = running & ~cnt_gate & ~capt_mode & cca_zero_ok
                   & ((cnt_ff == cca_ff)
                   | (owe_ff & (cnt_plus1 == cca_ff)));

    assign wrap_now = running & ~cnt_gate & (mode != `TC16_MODE_CLR_MAT
                    | ~match_a) & ((cnt_ff == 16'hffff)
                    | (owe_ff & (cnt_plus1 == 16'hffff)));

    // Captures act on synchronised edges only; a counter read is no trigger.
    assign capt_a = capt_mode & edge_a_rise;
    assign capt_b = ~pin_out & pin_b_rise;

    // Counter, owed count and wrap flag.
    always_comb begin
        nxt_cnt  = cnt_ff;
        nxt_owe  = owe_ff;
        nxt_wrap = wrap_ff;
        if (!running) begin
            nxt_cnt  = 16'h0000;
            nxt_owe  = 1'b0;
            nxt_wrap = 1'b0;
        end else if (cnt_gate) begin
            nxt_owe = 1'b1;
        end else begin
            nxt_owe = 1'b0;
            if (mode == `TC16_MODE_CLR_MAT && match_a) begin
                nxt_cnt = 16'h0000;
            end else if (mode == `TC16_MODE_CLR_EDG && edge_a_rise) begin
                nxt_cnt  = 16'h0000;
                nxt_wrap = 1'b0;
            end else begin
                nxt_cnt = cnt_step;
                if (wrap_now) begin
                    nxt_wrap = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_ff  <= 16'h0000;
            owe_ff  <= 1'b0;
            wrap_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            owe_ff  <= nxt_owe;
            wrap_ff <= nxt_wrap;
        end
    end

    // Control, mask and capture/compare registers. A capture on the same
    // edge as a software write to that register wins over the write.
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_mask = mask_ff;
        nxt_cca  = cca_ff;
        nxt_ccb  = ccb_ff;
        if (wr) begin
            case (paddr)
                `TC16_OFS_CTRL: nxt_ctrl = pwdata[`TC16_CTRL_W-1:0];
                `TC16_OFS_MASK: nxt_mask = pwdata[`TC16_ST_W-1:0];
                `TC16_OFS_CCA:  nxt_cca  = pwdata[15:0];
                `TC16_OFS_CCB:  nxt_ccb  = pwdata[15:0];
                default:        nxt_ctrl = ctrl_ff;
            endcase
        end
        // The counter is captured even if the timer stops on this edge;
        // the value is then whatever the counter shows.
        if (capt_a) begin
            nxt_cca = cnt_ff;
        end
        if (capt_b) begin
            nxt_ccb = cnt_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl_ff <= `TC16_RST_CTRL;
            mask_ff <= `TC16_RST_MASK;
            cca_ff  <= `TC16_RST_CC;
            ccb_ff  <= `TC16_RST_CC;
        end else begin
            ctrl_ff <= nxt_ctrl;
            mask_ff <= nxt_mask;
            cca_ff  <= nxt_cca;
            ccb_ff  <= nxt_ccb;
        end
    end

    // Sticky status: an event on the edge of a clearing read stays set.
    always_comb begin
        logic [`TC16_ST_W-1:0] ev;
        ev = '0;
        ev[`TC16_ST_CMP_A]  = match_a;
        ev[`TC16_ST_OVF]    = wrap_now;
        ev[`TC16_ST_CAPT_A] = capt_a;
        ev[`TC16_ST_CAPT_B] = capt_b;
        nxt_stat = stat_ff;
        if (rd && paddr == `TC16_OFS_STATUS) begin
            nxt_stat = '0;
        end
        nxt_stat = nxt_stat | ev;
        nxt_irq  = |(nxt_stat & mask_ff);
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stat_ff <= '0;
            irq_ff  <= 1'b0;
        end else begin
            stat_ff <= nxt_stat;
            irq_ff  <= nxt_irq;
        end
    end

    // Timer output toggles on each compare match; the pin is driven only
    // when it is selected as output, so it never doubles as input.
    always_comb begin
        nxt_tout = tout_ff;
        if (!running) begin
            nxt_tout = 1'b0;
        end else if (match_a) begin
            nxt_tout = ~tout_ff;
        end
        nxt_oe_b = ~pin_out;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tout_ff <= 1'b0;
            oe_b_ff <= 1'b1;
        end else begin
            tout_ff <= nxt_tout;
            oe_b_ff <= nxt_oe_b;
        end
    end

    // Bus answer: read data is taken in the setup cycle and pready rises
    // for the first access cycle, giving a fixed one-wait-free access.
    // A capture in the access cycle therefore leaves stale read data.
    always_comb begin
        nxt_rdat = rdat_ff;
        nxt_rdy  = 1'b0;
        if (setup) begin
            nxt_rdy  = 1'b1;
            nxt_rdat = 32'h0000_0000;
            if (!pwrite) begin
                case (paddr)
                    `TC16_OFS_CTRL:   nxt_rdat[`TC16_CTRL_W-1:0] = ctrl_ff;
                    `TC16_OFS_COUNT:  nxt_rdat[15:0] = cnt_ff;
                    `TC16_OFS_CCA:    nxt_rdat[15:0] = cca_ff;
                    `TC16_OFS_CCB:    nxt_rdat[15:0] = ccb_ff;
                    `TC16_OFS_STATUS: nxt_rdat[`TC16_ST_W-1:0] = stat_ff;
                    `TC16_OFS_MASK:   nxt_rdat[`TC16_ST_W-1:0] = mask_ff;
                    default:          nxt_rdat = 32'h0000_0000;
                endcase
            end
        end
    end

    // Unmapped addresses answer with an error and change nothing.
    assign nxt_err = setup & ~mapped;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdat_ff <= 32'h0000_0000;
            rdy_ff  <= 1'b0;
            err_ff  <= 1'b0;
        end else begin
            rdat_ff <= nxt_rdat;
            rdy_ff  <= nxt_rdy;
            err_ff  <= nxt_err;
        end
    end

    // Outputs straight from flip-flops.
    assign prdata               = rdat_ff;
    assign pready               = rdy_ff;
    assign pslverr              = err_ff;
    assign shared_port_pin_o    = tout_ff;
    assign shared_port_pin_oe_b = oe_b_ff;
    assign compare_a_irq        = irq_ff;

endmodule

`default_nettype wire

// ### dv/tc16_edge_model.sv
// Model of the two external edge sources that feed the timer.
// Assumes one-cycle request strobes from the bench on clk.
`timescale 1ns/100ps
`default_nettype none

module tc16_edge_model (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst_b,
    // Bench requests.
    input  wire logic req_a,
    input  wire logic req_b,
    // Pins as the timer sees them.
    input  wire logic shared_port_pin_o,
    input  wire logic shared_port_pin_oe_b,
    output logic      edge_input_a,
    output logic      shared_port_pin_i
);
    logic [2:0] len_a_ff;
    logic [2:0] len_b_ff;
    logic [2:0] nxt_len_a;
    logic [2:0] nxt_len_b;

    // A request becomes a four-cycle pulse, long enough for the synchroniser.
    always_comb begin
        nxt_len_a = (len_a_ff != 3'h0) ? len_a_ff - 3'h1 : 3'h0;
        nxt_len_b = (len_b_ff != 3'h0) ? len_b_ff - 3'h1 : 3'h0;
        if (req_a) begin
            nxt_len_a = 3'h4;
        end
        if (req_b) begin
            nxt_len_b = 3'h4;
        end
    end

    // Pulse counters.
    always_ff @(posedge clk) begin
        len_a_ff <= rst_b ? nxt_len_a : 3'h0;
        len_b_ff <= rst_b ? nxt_len_b : 3'h0;
    end

    // The far side drives the shared pin only while the timer has let go.
    assign edge_input_a      = (len_a_ff != 3'h0);
    assign shared_port_pin_i = shared_port_pin_oe_b
                             ? (len_b_ff != 3'h0)
                             : shared_port_pin_o;
endmodule
`default_nettype wire

// ### dv/tc16_timer_checker.sv
// Port-level assertions for the timer, bound into every tc16_timer.
// Assumes an APB master that keeps setup and access phases in order.
`timescale 1ns/100ps
`default_nettype none

`include "tc16_regs.svh"

module tc16_timer_checker #(
    parameter int CNT_W = 16
) (
    // Clock and reset.
    input wire logic        clk,
    input wire logic        rst_b,
    // APB.
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins and interrupt.
    input wire logic        edge_input_a,
    input wire logic        shared_port_pin_i,
    input wire logic        shared_port_pin_o,
    input wire logic        shared_port_pin_oe_b,
    input wire logic        compare_a_irq
);
    logic [1:0] mode_sh_ff;
    logic [1:0] nxt_mode_sh;
    logic [3:0] mask_sh_ff;
    logic [3:0] nxt_mask_sh;
    logic       pin_out_sh_ff;
    logic       nxt_pin_out_sh;
    logic       done_wr;

    // Shadows of CTRL and MASK, so pin and interrupt can be tied to them.
    always_comb begin
        done_wr        = psel && penable && pready && pwrite;
        nxt_mode_sh    = mode_sh_ff;
        nxt_pin_out_sh = pin_out_sh_ff;
        nxt_mask_sh    = mask_sh_ff;
        if (done_wr && paddr == `TC16_OFS_CTRL) begin
            nxt_mode_sh    = pwdata[1:0];
            nxt_pin_out_sh = pwdata[`TC16_CTRL_PIN_OUT];
        end
        if (done_wr && paddr == `TC16_OFS_MASK) begin
            nxt_mask_sh = pwdata[3:0];
        end
    end

    // Shadow registers.
    always_ff @(posedge clk) begin
        mode_sh_ff    <= rst_b ? nxt_mode_sh : 2'h0;
        pin_out_sh_ff <= rst_b ? nxt_pin_out_sh : 1'b0;
        mask_sh_ff    <= rst_b ? nxt_mask_sh : 4'h0;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_pready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_pready_has_cause: assert property (
        pready |-> psel && penable && $past(psel && !penable))
        else $error("pready without a setup cycle");
    a_slverr_unmapped: assert property (
        psel && !penable && paddr > 8'h14 |=> pready && pslverr)
        else $error("unmapped access not refused");
    a_mapped_no_err: assert property (
        psel && !penable && paddr <= 8'h14 && paddr[1:0] == 2'h0 |=> !pslverr)
        else $error("mapped access refused");
    a_ctrl_reserved_zero: assert property (
        pready && !pwrite && paddr == `TC16_OFS_CTRL |-> prdata[31:4] == 28'h0)
        else $error("reserved control bits not zero");
    a_pin_follows_ctrl: assert property (
        pin_out_sh_ff == $past(pin_out_sh_ff)
        |-> shared_port_pin_oe_b == !pin_out_sh_ff)
        else $error("pin direction differs from control");
    a_pin_low_stopped: assert property (
        (mode_sh_ff == 2'h0) [*3] |-> !shared_port_pin_o)
        else $error("timer output active while stopped");
    a_irq_on_match: assert property (
        $changed(shared_port_pin_o) && mode_sh_ff != 2'h0
        && $past(mode_sh_ff) != 2'h0 && mask_sh_ff[0] && $past(mask_sh_ff[0])
        |-> ##[0:3] compare_a_irq)
        else $error("match gave no interrupt");
    a_irq_masked_low: assert property (
        mask_sh_ff == 4'h0 && $past(mask_sh_ff) == 4'h0 |-> !compare_a_irq)
        else $error("interrupt while all masked");

    c_irq_raised: cover property ($rose(compare_a_irq));
    c_unmapped: cover property (pready && pslverr);
    c_pin_driven: cover property ($fell(shared_port_pin_oe_b));
endmodule

bind tc16_timer tc16_timer_checker #(.CNT_W(CNT_W)) u_tc16_timer_checker (
    .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .edge_input_a, .shared_port_pin_i,
    .shared_port_pin_o, .shared_port_pin_oe_b, .compare_a_irq
);
`default_nettype wire

// ### dv/timer16_capture_compare_ch0_test.sv
// Self-checking bench for the timer: APB tasks and directed tests.
// Assumes the edge model on the pins and the bound checker.
`timescale 1ns/100ps
`default_nettype none

`include "tc16_regs.svh"

module timer16_capture_compare_ch0_test;
    localparam int LIMIT = 80000;
    logic clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
    logic edge_input_a, pin_i, pin_o, oe_b, irq, req_a, req_b;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q, v, c0, c1;
    int failures = 0, n_checks = 0, cycles = 0, n;

    tc16_timer u_tc16_timer (
        .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .edge_input_a(edge_input_a),
        .shared_port_pin_i(pin_i), .shared_port_pin_o(pin_o),
        .shared_port_pin_oe_b(oe_b), .compare_a_irq(irq));
    tc16_edge_model u_tc16_edge_model (
        .clk(clk), .rst_b(rst_b), .req_a(req_a), .req_b(req_b),
        .shared_port_pin_o(pin_o), .shared_port_pin_oe_b(oe_b),
        .edge_input_a(edge_input_a), .shared_port_pin_i(pin_i));

    task report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task check(input string nm, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer; the request holds until pready is seen high.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rd(input logic [7:0] a, output logic [31:0] r);
        apb(1'b0, a, 32'h0);
        r = q;
    endtask

    task wait_irq(input int lim);
        n = 0;
        while (irq !== 1'b1 && n < lim) begin
            @(posedge clk);
            n++;
        end
        check("irq raised", {31'h0, irq}, 32'h1);
    endtask

    // Edge pulse on pin a or on the shared pin, then time to synchronise.
    task pulse(input logic b);
        if (b) req_b <= 1'b1;
        else req_a <= 1'b1;
        @(posedge clk);
        req_a <= 1'b0;
        req_b <= 1'b0;
        repeat (8) @(posedge clk);
    endtask

    // Free-running clock at 250 MHz.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // A hang is cut short here and counts as a mismatch.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            failures++;
            report_and_stop();
        end
    end

    initial begin
        rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; req_a = 1'b0; req_b = 1'b0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            rd(8'(i * 4), q);
            check("reset value", q, 32'h0);
        end
        wr(8'h18, 32'hffff_ffff);
        check("unmapped write", {31'h0, err}, 32'h1);
        rd(8'h18, q);
        check("unmapped read", {q[31:1], err}, 32'h1);
        rd(`TC16_OFS_COUNT, q);
        check("count at reset", q, 32'h0);
        check("pins after reset", {30'h0, oe_b, irq}, 32'h2);
        $display("test reset done");
        wr(`TC16_OFS_CCA, 32'h1000);
        for (int m = 1; m < 4; m++) begin
            wr(`TC16_OFS_CTRL, 32'(m));
            rd(`TC16_OFS_COUNT, c0);
            rd(`TC16_OFS_COUNT, c1);
            check("count no loss", c1 - c0, 32'h3);
            wr(`TC16_OFS_CTRL, 32'h0);
            rd(`TC16_OFS_COUNT, q);
            check("count stopped", q, 32'h0);
        end
        $display("test modes done");
        wr(`TC16_OFS_CCA, 32'h14);
        wr(`TC16_OFS_MASK, 32'h1);
        wr(`TC16_OFS_CTRL, 32'h3);
        wait_irq(100);
        // A landing write would lift the count above the compare value.
        wr(`TC16_OFS_COUNT, 32'h1234);
        for (int k = 0; k < 6; k++) begin
            rd(`TC16_OFS_COUNT, q);
            check("clear on match", {31'h0, q <= 32'h14}, 32'h1);
        end
        wr(`TC16_OFS_CTRL, 32'h0);
        rd(`TC16_OFS_STATUS, q);
        check("match flag", q, 32'h1);
        check("output low stopped", {31'h0, pin_o}, 32'h0);
        rd(`TC16_OFS_STATUS, q);
        check("flag cleared", q, 32'h0);
        repeat (2) @(posedge clk);
        check("irq cleared", {31'h0, irq}, 32'h0);
        $display("test match done");
        wr(`TC16_OFS_CCA, 32'h40); // Reloaded after the stop.
        wr(`TC16_OFS_CTRL, 32'h2);
        wait_irq(200);
        rd(`TC16_OFS_STATUS, q);
        check("free match", q, 32'h1);
        check("output toggled", {31'h0, pin_o}, 32'h1);
        wr(`TC16_OFS_CCA, 32'h0); // Now below the running count.
        wait_irq(70000);
        v = (n > 65000 && n < 65536);
        check("match after wrap", v, 32'h1);
        rd(`TC16_OFS_COUNT, q);
        check("zero compare", {31'h0, q <= 32'h8}, 32'h1);
        rd(`TC16_OFS_STATUS, q);
        check("wrap flags", q, 32'h3);
        $display("test wrap done");
        pulse(1'b0);
        rd(`TC16_OFS_CCA, q);
        check("compare ignores edge", q, 32'h0);
        rd(`TC16_OFS_COUNT, c0);
        pulse(1'b1);
        rd(`TC16_OFS_CCB, v);
        rd(`TC16_OFS_COUNT, c1);
        check("capture b", {31'h0, v > c0 && v < c1}, 32'h1);
        rd(`TC16_OFS_COUNT, q);
        rd(`TC16_OFS_CCB, q);
        check("count read no capture", q, v);
        rd(`TC16_OFS_STATUS, q);
        check("only b captured", q, 32'h8);
        wr(`TC16_OFS_CTRL, 32'h6);
        rd(`TC16_OFS_COUNT, c0);
        pulse(1'b0);
        rd(`TC16_OFS_CCA, q);
        check("capture a", {31'h0, q > c0}, 32'h1);
        rd(`TC16_OFS_STATUS, q);
        check("a captured", q, 32'h4);
        wr(`TC16_OFS_CTRL, 32'ha);
        wr(`TC16_OFS_CCA, 32'h8000);
        check("pin driven", {31'h0, oe_b}, 32'h0);
        pulse(1'b1);
        rd(`TC16_OFS_CCB, q);
        check("output pin no capture", q, v);
        rd(`TC16_OFS_STATUS, q);
        check("no capture flag", q, 32'h0);
        wr(`TC16_OFS_CTRL, 32'h1);
        repeat (40) @(posedge clk);
        pulse(1'b0);
        rd(`TC16_OFS_COUNT, q);
        check("clear on edge", {31'h0, q <= 32'h10}, 32'h1);
        $display("test capture done");
        report_and_stop();
    end
endmodule
`default_nettype wire
